// [hw/sdp_defines.svh]
/*
 * Shared constants of the sdram pin interface: mode word fields, address
 * bit positions, reset values and widths. Assumes inclusion by bare name.
 */
`ifndef SDP_DEFINES_SVH
`define SDP_DEFINES_SVH

// ----------------------------------------------------------------------
// address and bank widths
// ----------------------------------------------------------------------
`define SDP_ADDR_W        11
`define SDP_BANK_W        2
`define SDP_NUM_BANKS     4
`define SDP_COL_W         8
`define SDP_DATA_W        32
`define SDP_LANES         4
`define SDP_PREFLAG_BIT   10

// ----------------------------------------------------------------------
// mode word fields and reset values
// ----------------------------------------------------------------------
`define SDP_BL_LSB        0
`define SDP_BL_MSB        2
`define SDP_BL_FULL       3'h7
`define SDP_MODE_RST      11'h000
`define SDP_PAGE_LAST     8'hff
`define SDP_FIFO_DEPTH    8

`endif

// [hw/sdp_pkg.sv]
/*
 * Types of the sdram pin interface: command codes and power modes.
 * Assumes nothing of its surroundings.
 */
package sdp_pkg;

   // {row strobe, column strobe, write strobe}, all active low
   typedef enum logic [2:0] {
      SDP_CMD_LMR = 3'b000,
      SDP_CMD_REF = 3'b001,
      SDP_CMD_PRE = 3'b010,
      SDP_CMD_ACT = 3'b011,
      SDP_CMD_WR  = 3'b100,
      SDP_CMD_RD  = 3'b101,
      SDP_CMD_BST = 3'b110,
      SDP_CMD_NOP = 3'b111
   } sdp_cmd_t;

   typedef enum logic [2:0] {
      SDP_MD_RUN    = 3'b000,
      SDP_MD_PD_PRE = 3'b001,
      SDP_MD_SELF   = 3'b010,
      SDP_MD_PD_ACT = 3'b011,
      SDP_MD_SUSP   = 3'b100
   } sdp_mode_t;

endpackage

// [hw/sdp_fifo.sv]
/*
 * Small flip-flop FIFO with valid/ready on both sides.
 * Assumes one clock and a synchronous active-high reset.
 */
`timescale 1ns/100ps
module sdp_fifo #(
   parameter int W = 8,
   parameter int D = 8
) (
   input  wire logic         clk,
   input  wire logic         srst,
   input  wire logic         in_valid,
   output logic              in_ready,
   input  wire logic [W-1:0] in_data,
   output logic              out_valid,
   input  wire logic         out_ready,
   output logic      [W-1:0] out_data
);
   localparam int AW = (D > 1) ? $clog2(D) : 1;

   logic [W-1:0]  mem [D];
   logic [AW-1:0] wr_ptr;
   logic [AW-1:0] rd_ptr;
   logic [AW:0]   count;
   logic          push;
   logic          pop;

   // ----------------------------------------------------------------------
   // flags
   // ----------------------------------------------------------------------
   assign in_ready  = (count != (AW+1)'(D));
   assign out_valid = (count != '0);
   assign out_data  = mem[rd_ptr];
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   // storage, written only on an accepted push
   always_ff @(posedge clk) begin
      if (push) begin
         mem[wr_ptr] <= in_data;
      end
   end

   // pointers wrap at depth, which need not be a power of two
   always_ff @(posedge clk) begin
      if (srst) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count  <= '0;
      end else begin
         if (push) begin
            wr_ptr <= (wr_ptr == AW'(D - 1)) ? '0 : wr_ptr + AW'(1);
         end
         if (pop) begin
            rd_ptr <= (rd_ptr == AW'(D - 1)) ? '0 : rd_ptr + AW'(1);
         end
         count <= count + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule

// [hw/sdp_bank.sv]
/*
 * Open-row tracker of one bank: open flag and latched row.
 * Assumes activate and precharge strobes are one-cycle pulses.
 */
`timescale 1ns/100ps
module sdp_bank #(
   parameter int ROW_W = 11
) (
   input  wire logic             clk,
   input  wire logic             srst,
   input  wire logic             act,
   input  wire logic             pre,
   input  wire logic [ROW_W-1:0] row_in,
   output logic                  is_open,
   output logic      [ROW_W-1:0] row
);
   // activate wins over a same-cycle precharge of this bank
   always_ff @(posedge clk) begin
      if (srst) begin
         is_open <= 1'b0;
         row     <= '0;
      end else if (act) begin
         is_open <= 1'b1;
         row     <= row_in;
      end else if (pre) begin
         is_open <= 1'b0;
      end
   end
endmodule

// [hw/sdp_pin_if.sv]
/*
 * Device-side pin command and data interface of a quad-bank 32-bit sdram:
 * pin synchronisers, clock-gate modes, command decode, bank row state,
 * burst sequencing, byte masks, write FIFO and read output registers.
 * Assumes a memory array behind arr_* with combinational read data and
 * a write port that may stall; pins arrive from outside the clock domain.
 */
// Function
// - every pin is captured only on the rising clock edge
// - burst column counter and output registers advance on clock edges
// - clock gate high means clock active, low means stopped; may stay high
// - gate low picks precharge power-down, self refresh, active power-down or suspend
// - gate sampled synchronously, but power-down and self refresh exit on it directly; here exit waits for the synchronised gate at a clock edge
// - input buffers including clock are disabled in power-down and self refresh
// - command decoder runs only with chip select low; otherwise commands ignored
// - command comes from row, column, write strobes and chip select together
// - write data on a lane with mask high is discarded
// - read lane goes high impedance two clocks after its mask is high; here four clocks after the mask pin, two after the synchronised mask
// - mask bit n governs data byte lane n, lowest byte first
// - two bank-select bits name the bank of activate, read, write, precharge
// - eleven-bit row at activate, eight-bit start column at read or write
// - precharge flag bit at read or write requests auto precharge at burst end
// - precharge flag bit high precharges all banks, low only the named bank
// - mode-register load takes its opcode from the address inputs
// - read and write data share one 32-bit two-way bus
// - burst lengths of one, two, four, eight or full page with terminate
`timescale 1ns/100ps
`include "sdp_defines.svh"
module sdp_pin_if
   import sdp_pkg::*;
#(
   parameter int FIFO_DEPTH = `SDP_FIFO_DEPTH
) (
   input  wire logic                       clk,
   input  wire logic                       srst,
   input  wire logic                       cke,
   input  wire logic                       cs_n,
   input  wire logic                       ras_n,
   input  wire logic                       cas_n,
   input  wire logic                       we_n,
   input  wire logic [`SDP_LANES-1:0]      dqm,
   input  wire logic [`SDP_BANK_W-1:0]     ba,
   input  wire logic [`SDP_ADDR_W-1:0]     addr,
   input  wire logic [`SDP_DATA_W-1:0]     dq_in,
   output logic      [`SDP_DATA_W-1:0]     dq_out,
   output logic      [`SDP_LANES-1:0]      dq_oe,
   output logic                            input_buf_en,
   output sdp_mode_t                       pwr_mode,
   output logic      [`SDP_ADDR_W-1:0]     mode_word,
   output logic                            wr_path_ready,
   output logic                            arr_rd_en,
   output logic      [`SDP_BANK_W-1:0]     arr_rd_bank,
   output logic      [`SDP_ADDR_W-1:0]     arr_rd_row,
   output logic      [`SDP_COL_W-1:0]      arr_rd_col,
   input  wire logic [`SDP_DATA_W-1:0]     arr_rd_data,
   output logic                            arr_wr_valid,
   input  wire logic                       arr_wr_ready,
   output logic      [`SDP_BANK_W-1:0]     arr_wr_bank,
   output logic      [`SDP_ADDR_W-1:0]     arr_wr_row,
   output logic      [`SDP_COL_W-1:0]      arr_wr_col,
   output logic      [`SDP_LANES-1:0]      arr_wr_be,
   output logic      [`SDP_DATA_W-1:0]     arr_wr_data
);
   localparam int PIN_W = 5 + `SDP_LANES + `SDP_BANK_W + `SDP_ADDR_W + `SDP_DATA_W;
   localparam int WF_W  = `SDP_BANK_W + `SDP_ADDR_W + `SDP_COL_W + `SDP_LANES
                          + `SDP_DATA_W;

   // ----------------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------------
   logic [PIN_W-1:0]          pin_s1;
   logic [PIN_W-1:0]          pin_s2;
   logic                      cke_s;
   logic                      cs_n_s;
   logic [2:0]                strb_s;
   logic [`SDP_LANES-1:0]     dqm_s;
   logic [`SDP_BANK_W-1:0]    ba_s;
   logic [`SDP_ADDR_W-1:0]    addr_s;
   logic [`SDP_DATA_W-1:0]    dq_s;

   // rising edge capture
   // two stages because the controller's pins are foreign to this clock
   always_ff @(posedge clk) begin
      pin_s1 <= {cke, cs_n, ras_n, cas_n, we_n, dqm, ba, addr, dq_in};
      pin_s2 <= pin_s1;
   end
   assign {cke_s, cs_n_s, strb_s, dqm_s, ba_s, addr_s, dq_s} = pin_s2;

   // ----------------------------------------------------------------------
   // power modes
   // ----------------------------------------------------------------------
   sdp_mode_t st;
   logic      cke_q;
   logic      clk_active;
   logic      any_open;
   logic      bst_act;
   logic      cmd_valid;
   sdp_cmd_t  cmd;

   // previous gate level decides whether this edge counts
   always_ff @(posedge clk) begin
      if (srst) begin
         cke_q <= 1'b0;
      end else begin
         cke_q <= cke_s;
      end
   end

   assign clk_active   = (st == SDP_MD_RUN) && cke_q;
   assign input_buf_en = (st != SDP_MD_PD_PRE) && (st != SDP_MD_PD_ACT)
                         && (st != SDP_MD_SELF);
   assign pwr_mode     = st;

   always_ff @(posedge clk) begin
      if (srst) begin
         st <= SDP_MD_RUN;
      end else begin
         unique case (st)
            SDP_MD_RUN: begin
               if (!cke_s) begin
                  if (bst_act) begin
                     st <= SDP_MD_SUSP;
                  end else if (any_open) begin
                     st <= SDP_MD_PD_ACT;
                  end else if (cmd_valid && cmd == SDP_CMD_REF) begin
                     st <= SDP_MD_SELF;
                  end else begin
                     st <= SDP_MD_PD_PRE;
                  end
               end
            end
            // sleep exit on gate level alone
            SDP_MD_PD_PRE, SDP_MD_PD_ACT, SDP_MD_SELF, SDP_MD_SUSP: begin
               if (cke_s) begin
                  st <= SDP_MD_RUN;
               end
            end
            default: st <= SDP_MD_RUN;
         endcase
      end
   end

   // ----------------------------------------------------------------------
   // command decode
   // ----------------------------------------------------------------------
   // strobes and select together
   assign cmd = sdp_cmd_t'(strb_s);
   assign cmd_valid = clk_active && !cs_n_s;

   // ----------------------------------------------------------------------
   // bank row state
   // ----------------------------------------------------------------------
   logic [`SDP_NUM_BANKS-1:0] bank_open;
   logic [`SDP_ADDR_W-1:0]    bank_row [`SDP_NUM_BANKS];
   logic [`SDP_NUM_BANKS-1:0] bank_act;
   logic [`SDP_NUM_BANKS-1:0] bank_pre;
   logic [`SDP_BANK_W-1:0]    cur_bank;
   logic                      bst_ap, single_ap;
   logic                      bst_end;
   logic                      pre_all;

   assign pre_all  = cmd_valid && cmd == SDP_CMD_PRE && addr_s[`SDP_PREFLAG_BIT];
   assign any_open = |bank_open;

   for (genvar b = 0; b < `SDP_NUM_BANKS; b++) begin : g_bank
      assign bank_act[b] = cmd_valid && cmd == SDP_CMD_ACT && ba_s == `SDP_BANK_W'(b);
      // all banks or the named one
      assign bank_pre[b] = pre_all
                           || (((cmd_valid && cmd == SDP_CMD_PRE) || single_ap)
                               && ba_s == `SDP_BANK_W'(b))
                           || (bst_end && bst_ap && cur_bank == `SDP_BANK_W'(b));
      sdp_bank #(
         .ROW_W (`SDP_ADDR_W)
      ) u_bank (
         .clk     (clk),
         .srst    (srst),
         .act     (bank_act[b]),
         .pre     (bank_pre[b]),
         .row_in  (addr_s),
         .is_open (bank_open[b]),
         .row     (bank_row[b])
      );
   end

   // ----------------------------------------------------------------------
   // mode word
   // ----------------------------------------------------------------------
   logic [7:0] len_m1;

   always_ff @(posedge clk) begin
      if (srst) begin
         mode_word <= `SDP_MODE_RST;
      end else if (cmd_valid && cmd == SDP_CMD_LMR && !any_open) begin
         mode_word <= addr_s;
      end
   end

   always_comb begin
      unique case (mode_word[`SDP_BL_MSB:`SDP_BL_LSB])
         3'h0:         len_m1 = 8'h00;
         3'h1:         len_m1 = 8'h01;
         3'h2:         len_m1 = 8'h03;
         3'h3:         len_m1 = 8'h07;
         `SDP_BL_FULL: len_m1 = `SDP_PAGE_LAST;
         default:      len_m1 = 8'h00;
      endcase
   end

   // ----------------------------------------------------------------------
   // burst sequencer
   // ----------------------------------------------------------------------
   logic                   start;
   logic                   acc_now;
   logic                   bst_wr;
   logic [7:0]             bst_left;
   logic [`SDP_COL_W-1:0]  cur_col;
   logic [`SDP_COL_W-1:0]  acc_col;
   logic [`SDP_BANK_W-1:0] acc_bank;
   logic                   acc_wr;
   logic                   term;
   logic [`SDP_COL_W-1:0]  next_col;

   // a closed bank ignores read and write
   assign start   = cmd_valid && (cmd == SDP_CMD_RD || cmd == SDP_CMD_WR)
                    && bank_open[ba_s];
   assign term    = cmd_valid && cmd == SDP_CMD_BST;
   assign acc_now = start || (bst_act && clk_active && !term);
   assign acc_col  = start ? addr_s[`SDP_COL_W-1:0] : cur_col;
   assign acc_bank = start ? ba_s : cur_bank;
   assign acc_wr   = start ? (cmd == SDP_CMD_WR) : bst_wr;
   assign bst_end  = bst_act && clk_active && !start && (term || bst_left == 8'h01);
   // column wraps inside the burst-aligned block
   assign next_col = (acc_col & ~len_m1) | ((acc_col + 8'h01) & len_m1);

   always_ff @(posedge clk) begin
      if (srst) begin
         bst_act  <= 1'b0;
         bst_wr   <= 1'b0;
         bst_ap   <= 1'b0;
         bst_left <= 8'h00;
         cur_col  <= '0;
         cur_bank <= '0;
      end else if (start) begin
         bst_act  <= (len_m1 != 8'h00);
         bst_wr   <= (cmd == SDP_CMD_WR);
         bst_ap   <= addr_s[`SDP_PREFLAG_BIT];
         bst_left <= len_m1;
         cur_col  <= next_col;
         cur_bank <= ba_s;
      end else if (bst_end) begin
         bst_act <= 1'b0;
      end else if (acc_now) begin
         bst_left <= bst_left - 8'h01;
         cur_col  <= next_col;
      end
   end

   // a one-location burst with auto precharge closes at once
   assign single_ap = start && len_m1 == 8'h00 && addr_s[`SDP_PREFLAG_BIT];

   // ----------------------------------------------------------------------
   // write path through the FIFO
   // ----------------------------------------------------------------------
   logic              wf_in_valid;
   logic [WF_W-1:0]   wf_in_data;
   logic [WF_W-1:0]   wf_out_data;

   assign wf_in_valid = acc_now && acc_wr;
   // mask bit n to byte lane n
   assign wf_in_data  = {acc_bank, bank_row[acc_bank], acc_col, ~dqm_s, dq_s};
   assign {arr_wr_bank, arr_wr_row, arr_wr_col, arr_wr_be, arr_wr_data} = wf_out_data;

   // pins cannot stall, so a full FIFO drops data; wr_path_ready shows it
   sdp_fifo #(
      .W (WF_W),
      .D (FIFO_DEPTH)
   ) u_wfifo (
      .clk       (clk),
      .srst      (srst),
      .in_valid  (wf_in_valid),
      .in_ready  (wr_path_ready),
      .in_data   (wf_in_data),
      .out_valid (arr_wr_valid),
      .out_ready (arr_wr_ready),
      .out_data  (wf_out_data)
   );

   // ----------------------------------------------------------------------
   // read path and output registers
   // ----------------------------------------------------------------------
   logic [`SDP_LANES-1:0] dqm_d1;

   // read address registered one edge after the access
   always_ff @(posedge clk) begin
      if (srst) begin
         arr_rd_en   <= 1'b0;
         arr_rd_bank <= '0;
         arr_rd_row  <= '0;
         arr_rd_col  <= '0;
      end else begin
         arr_rd_en   <= acc_now && !acc_wr;
         arr_rd_bank <= acc_bank;
         arr_rd_row  <= bank_row[acc_bank];
         arr_rd_col  <= acc_col;
      end
   end

   // one shared bus, lanes driven only during reads
   always_ff @(posedge clk) begin
      if (srst) begin
         dqm_d1 <= '0;
         dq_oe  <= '0;
         dq_out <= '0;
      end else begin
         dqm_d1 <= dqm_s;
         dq_oe  <= {`SDP_LANES{arr_rd_en}} & ~dqm_d1;
         if (arr_rd_en) begin
            dq_out <= arr_rd_data;
         end
      end
   end

   // ----------------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);

   a_cs_mask_cmd: assert property (cs_n_s |-> !start && !(|bank_act))
      else $error("command taken with select high");
   a_hiz_two_clk: assert property (dqm_s[2] |-> ##2 !dq_oe[2])
      else $error("lane 2 driven two clocks after mask");
   a_wr_lane_mask: assert property (wf_in_valid && dqm_s[1] |-> !wf_in_data[33])
      else $error("masked write lane enabled");
   a_act_opens_row: assert property (bank_act[2] && !bank_pre[2]
      |=> bank_open[2] && bank_row[2] == $past(addr_s))
      else $error("activate did not open bank row");
   a_pre_all_banks: assert property (pre_all && !(|bank_act) |=> bank_open == '0)
      else $error("all-bank precharge left a bank open");
   a_suspend_burst: assert property (st == SDP_MD_RUN && !cke_s && bst_act
      |=> st == SDP_MD_SUSP && !clk_active)
      else $error("suspend not entered during burst");
   a_sleep_bufs_off: assert property (st == SDP_MD_RUN && !cke_s && !bst_act && any_open
      |=> !input_buf_en ##1 !input_buf_en || cke_s)
      else $error("buffers on in power-down");
   a_lmr_loads_word: assert property (cmd_valid && cmd == SDP_CMD_LMR && !any_open
      |=> mode_word == $past(addr_s))
      else $error("mode word not loaded");
   a_burst_four: assert property (start && len_m1 == 8'h03 && cke_s && cke_q
      ##1 (!cmd_valid && cke_s)[*3] |=> !bst_act)
      else $error("burst of four did not end");
   a_auto_pre: assert property (bst_end && bst_ap && !(|bank_act)
      |=> !bank_open[$past(cur_bank)])
      else $error("auto precharge missed");
   a_single_ap: assert property (single_ap && !(|bank_act) |=> !bank_open[$past(ba_s)])
      else $error("one-beat precharge missed");

   c_read_start:  cover property (start && cmd == SDP_CMD_RD);
   c_write_start: cover property (start && cmd == SDP_CMD_WR);
   c_self_ref:    cover property (st == SDP_MD_SELF);
   c_suspend:     cover property (st == SDP_MD_SUSP);
endmodule

// [tb/sdp_ctrl_model.sv]
/*
 * Controller-side model: drives the sdram pins and resolves the data bus.
 * Assumes the device samples every pin on the rising edge of clk.
 */
`timescale 1ns/100ps
module sdp_ctrl_model
   import sdp_pkg::*;
(
   input  wire logic        clk,
   output logic             cke,
   output logic             cs_n,
   output logic             ras_n,
   output logic             cas_n,
   output logic             we_n,
   output logic [3:0]       dqm,
   output logic [1:0]       ba,
   output logic [10:0]      addr,
   output logic [31:0]      dq_in,
   input  wire logic [31:0] dq_out,
   input  wire logic [3:0]  dq_oe
);
   logic        drv = 1'b0;
   logic [31:0] wdata = 32'h0000_0000;
   logic [31:0] last = 32'h0000_0000;

   // ----------------------------------------------------------------
   // pin drive
   // ----------------------------------------------------------------
   // clock gate starts high
   initial begin
      cke = 1'b1;
      {cs_n, ras_n, cas_n, we_n} = 4'hf;
      dqm = 4'h0;
      ba = 2'd0;
      addr = 11'h000;
   end

   // strobes, bank and address change together
   task automatic cmd(input sdp_cmd_t c, input logic [1:0] b, input logic [10:0] a,
                      input logic sel_n = 1'b0, input logic ck = 1'b1);
      @(negedge clk);
      {ras_n, cas_n, we_n} = c;
      cs_n = sel_n;
      cke = ck;
      ba = b;
      addr = a;
      @(negedge clk);
      {cs_n, ras_n, cas_n, we_n} = 4'hf;
   endtask

   // write beats start with the command and run back to back, bank already open
   task automatic wr(input logic [1:0] b, input logic [7:0] col, input int n,
                     input logic [3:0] m);
      @(negedge clk);
      {cs_n, ras_n, cas_n, we_n} = {1'b0, SDP_CMD_WR};
      ba = b;
      addr = {3'b000, col};
      dqm = m;
      drv = 1'b1;
      for (int k = 0; k < n; k++) begin
         wdata = 32'h1111_1111 * (k + 1);
         @(negedge clk);
         {cs_n, ras_n, cas_n, we_n} = 4'hf;
      end
      drv = 1'b0;
      dqm = 4'h0;
   endtask

   // released lanes show the inverse of the last value, never stale data
   always_comb begin
      for (int l = 0; l < 4; l++) begin
         if (dq_oe[l])
            dq_in[8*l +: 8] = dq_out[8*l +: 8];
         else if (drv)
            dq_in[8*l +: 8] = wdata[8*l +: 8];
         else
            dq_in[8*l +: 8] = ~last[8*l +: 8];
      end
   end

   // last bus level for the release pattern
   always @(posedge clk) last <= dq_in;
endmodule

// [tb/test_sdram_pin_command_interface.sv]
/*
 * Self-checking bench of the sdram pin interface: bursts, masks, write FIFO,
 * refused commands and clock-gate modes.
 * Assumes sdp_ctrl_model on the pins and a combinational array read port.
 */
`timescale 1ns/100ps
`include "sdp_defines.svh"
module test_sdram_pin_command_interface
   import sdp_pkg::*;
;
   logic        clk = 1'b0;
   logic        srst = 1'b1;
   logic        arr_wr_ready = 1'b1;
   logic        cke, cs_n, ras_n, cas_n, we_n, arr_rd_en, arr_wr_valid, wr_path_ready;
   logic        input_buf_en;
   logic [3:0]  dqm, dq_oe, arr_wr_be;
   logic [1:0]  ba, arr_rd_bank, arr_wr_bank;
   logic [10:0] addr, mode_word, arr_rd_row, arr_wr_row;
   logic [7:0]  arr_rd_col, arr_wr_col;
   logic [31:0] dq_in, dq_out, arr_rd_data, arr_wr_data;
   sdp_mode_t   pwr_mode;
   int          n_fail = 0;
   int          samples_checked = 0;

   // ----------------------------------------------------------------
   // clock, array and instances
   // ----------------------------------------------------------------
   // 40 MHz clock
   always #12.5 clk = ~clk;
   // array data carries its address so every beat is unique
   assign arr_rd_data = {arr_rd_bank, arr_rd_row, arr_rd_col, 11'h2a5};

   sdp_ctrl_model i_sdp_ctrl_model (.clk(clk), .cke(cke), .cs_n(cs_n), .ras_n(ras_n),
      .cas_n(cas_n), .we_n(we_n), .dqm(dqm), .ba(ba), .addr(addr), .dq_in(dq_in),
      .dq_out(dq_out), .dq_oe(dq_oe));
   sdp_pin_if i_sdp_pin_if (.clk(clk), .srst(srst), .cke(cke), .cs_n(cs_n), .ras_n(ras_n),
      .cas_n(cas_n), .we_n(we_n), .dqm(dqm), .ba(ba), .addr(addr), .dq_in(dq_in),
      .dq_out(dq_out), .dq_oe(dq_oe), .input_buf_en(input_buf_en), .pwr_mode(pwr_mode),
      .mode_word(mode_word), .wr_path_ready(wr_path_ready), .arr_rd_en(arr_rd_en),
      .arr_rd_bank(arr_rd_bank), .arr_rd_row(arr_rd_row), .arr_rd_col(arr_rd_col),
      .arr_rd_data(arr_rd_data), .arr_wr_valid(arr_wr_valid), .arr_wr_ready(arr_wr_ready),
      .arr_wr_bank(arr_wr_bank), .arr_wr_row(arr_wr_row), .arr_wr_col(arr_wr_col),
      .arr_wr_be(arr_wr_be), .arr_wr_data(arr_wr_data));

   task automatic final_report();
      if (n_fail == 0 && samples_checked > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   task automatic chk(input logic ok, input string m);
      samples_checked++;
      if (ok !== 1'b1) begin
         n_fail++;
         $display("FAIL %0t %s", $time, m);
      end
   endtask

   // a wait that runs out ends the run
   task automatic tmo();
      n_fail++;
      $display("FAIL %0t wait limit", $time);
      final_report();
   endtask

   task automatic wait_oe();
      for (int i = 0; i < 12; i++) begin
         @(negedge clk);
         if (dq_oe !== 4'h0) return;
      end
      tmo();
   endtask

   task automatic no_oe(input string m);
      logic seen;
      seen = 1'b0;
      repeat (10) begin
         @(negedge clk);
         if (dq_oe !== 4'h0) seen = 1'b1;
      end
      chk(!seen, m);
   endtask

   task automatic wait_mode(input sdp_mode_t md);
      for (int i = 0; i < 12; i++) begin
         @(negedge clk);
         if (pwr_mode === md) return;
      end
      tmo();
   endtask

   // close all banks, load burst code, open bank 1 row 555
   task automatic setup(input logic [2:0] code);
      i_sdp_ctrl_model.cmd(SDP_CMD_PRE, 2'd0, 11'h400);
      i_sdp_ctrl_model.cmd(SDP_CMD_LMR, 2'd0, {8'h00, code});
      i_sdp_ctrl_model.cmd(SDP_CMD_ACT, 2'd1, 11'h555);
      repeat (4) @(negedge clk);
      chk(mode_word === {8'h00, code}, "mode word");
   endtask

   // read burst with wrap; lane mask raised at beat 0, deselected meanwhile
   task automatic t_read(input logic [2:0] code, input logic [7:0] col, input logic [3:0] m);
      int         n;
      logic [7:0] c;
      n = 1 << code;
      setup(code);
      i_sdp_ctrl_model.cmd(SDP_CMD_RD, 2'd1, {3'b000, col});
      wait_oe();
      i_sdp_ctrl_model.dqm = m;
      for (int k = 0; k < n; k++) begin
         c = (col & ~8'(n - 1)) | (8'(col + k) & 8'(n - 1));
         if (k < 5) chk(dq_out === {2'd1, 11'h555, c, 11'h2a5}, "read data");
         chk(dq_oe === ((k >= 4) ? ~m : 4'hf), "lane enable");
         @(negedge clk);
      end
      chk(dq_oe === 4'h0, "burst length");
      i_sdp_ctrl_model.dqm = 4'h0;
   endtask

   // masked burst 8 fills the stalled FIFO, then drains in wrap order
   task automatic t_write();
      logic [7:0] c;
      setup(3'd3);
      arr_wr_ready = 1'b0;
      i_sdp_ctrl_model.wr(2'd1, 8'h26, 8, 4'b0100);
      repeat (4) @(negedge clk);
      chk(wr_path_ready === 1'b0 && arr_wr_valid === 1'b1, "fifo full");
      arr_wr_ready = 1'b1;
      for (int k = 0; k < 8; k++) begin
         c = 8'h20 | 8'((6 + k) & 7);
         chk(arr_wr_valid === 1'b1 && arr_wr_col === c, "write column");
         chk(arr_wr_bank === 2'd1 && arr_wr_row === 11'h555, "write row");
         chk(arr_wr_be === 4'b1011, "byte enables");
         chk((arr_wr_data & 32'hff00_ffff) === 32'((k + 1) * 32'h1111_1111 & 32'hff00_ffff),
             "write data");
         @(negedge clk);
      end
      chk(arr_wr_valid === 1'b0 && wr_path_ready === 1'b1, "fifo drained");
   endtask

   // deselected, closed-bank and auto-precharged accesses are refused
   task automatic t_refuse();
      setup(3'd0);
      i_sdp_ctrl_model.cmd(SDP_CMD_ACT, 2'd2, 11'h0aa, 1'b1);
      i_sdp_ctrl_model.cmd(SDP_CMD_RD, 2'd2, 11'h000);
      no_oe("deselected activate");
      i_sdp_ctrl_model.cmd(SDP_CMD_ACT, 2'd2, 11'h0aa);
      i_sdp_ctrl_model.cmd(SDP_CMD_PRE, 2'd2, 11'h000);
      i_sdp_ctrl_model.cmd(SDP_CMD_RD, 2'd1, 11'h400);
      wait_oe();
      chk(dq_out === {2'd1, 11'h555, 8'h00, 11'h2a5}, "other bank row");
      i_sdp_ctrl_model.cmd(SDP_CMD_RD, 2'd1, 11'h000);
      no_oe("auto precharge");
      i_sdp_ctrl_model.cmd(SDP_CMD_RD, 2'd2, 11'h000);
      no_oe("single precharge");
   endtask

   // each clock-gate mode entered from its own state and left again
   task automatic t_power();
      setup(3'd3);
      i_sdp_ctrl_model.cmd(SDP_CMD_RD, 2'd1, 11'h000);
      wait_oe();
      i_sdp_ctrl_model.cke = 1'b0;
      wait_mode(SDP_MD_SUSP);
      i_sdp_ctrl_model.cke = 1'b1;
      wait_mode(SDP_MD_RUN);
      repeat (12) @(negedge clk);
      i_sdp_ctrl_model.cke = 1'b0;
      wait_mode(SDP_MD_PD_ACT);
      chk(input_buf_en === 1'b0, "buffers in power-down");
      i_sdp_ctrl_model.cke = 1'b1;
      wait_mode(SDP_MD_RUN);
      chk(input_buf_en === 1'b1, "buffers running");
      i_sdp_ctrl_model.cmd(SDP_CMD_PRE, 2'd0, 11'h400);
      i_sdp_ctrl_model.cmd(SDP_CMD_REF, 2'd0, 11'h000, 1'b0, 1'b0);
      wait_mode(SDP_MD_SELF);
      i_sdp_ctrl_model.cke = 1'b1;
      wait_mode(SDP_MD_RUN);
      i_sdp_ctrl_model.cmd(SDP_CMD_NOP, 2'd0, 11'h000, 1'b0, 1'b0);
      wait_mode(SDP_MD_PD_PRE);
      i_sdp_ctrl_model.cke = 1'b1;
      wait_mode(SDP_MD_RUN);
   endtask

   // main sequence
   initial begin
      repeat (12) @(negedge clk);
      srst = 1'b0;
      chk(dq_oe === 4'h0 && pwr_mode === SDP_MD_RUN, "reset outputs");
      chk(mode_word === `SDP_MODE_RST && arr_wr_valid === 1'b0, "reset word");
      repeat (3) @(negedge clk);
      for (int c = 0; c < 4; c++)
         t_read(3'(c), 8'h3d, 4'b0100);
      t_write();
      t_refuse();
      t_power();
      final_report();
   end
endmodule
